// File: bench/usart_timeguard_iso_irda_regs_tb.sv
/*
  Self-checking bench of the auxiliary serial registers: an AHB-Lite
  master, a register model and checks of the timing outputs.
  Assumes utg_pkg, utg_aux_regs and utg_peer are compiled first.
*/
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin \
  failures++; $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module usart_timeguard_iso_irda_regs_tb;
  import utg_pkg::*;
  // ==========================================================
  // Bench signals; those the bench drives have a value at time zero.
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hready, hresp, tx_hold, sck, bit_tick, irda_f, irq;
  logic        char_done, card_error, irda_rx;
  logic [31:0] seed = 32'h3b;
  logic [31:0] mdl [8];
  int          failures = 0;
  int          tests_run = 0;
  int          lows = 0;

  // Free running clock; lows counts cycles the filtered line sat low.
  always #4 clk = ~clk;
  always @(posedge clk) if (irda_f === 1'b0) lows <= lows + 1;

  utg_aux_regs i_utg_aux_regs (.i_clock(clk), .i_sys_rst(rst),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_char_done(char_done), .i_card_error(card_error),
    .i_irda_rx(irda_rx), .o_tx_hold(tx_hold), .o_sck(sck),
    .o_bit_tick(bit_tick), .o_irda_rx_filtered(irda_f), .o_irq(irq));
  utg_peer i_utg_peer (.i_clock(clk), .o_char_done(char_done),
    .o_card_error(card_error), .o_irda_rx(irda_rx));

  // ==========================================================
  // Helpers: random source, field masks, verdict.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] msk(input int a);
    case (a)
      1: return 32'h7ff;
      4, 6, 7: return 32'h3;
      5: return 32'hffff;
      default: return 32'hff;
    endcase
  endfunction

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // Bus master: every wait is bounded so a dead slave ends the run.
  task automatic wait_rdy();
    int k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 64);
    if (k >= 64) begin
      failures++;
      give_verdict();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    `CHK("register read", e, v)
    `CHK("bus response", 1'b0, hresp) // Always OKAY.
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask

  // Cycles between bit ticks; the first two gaps are skipped because a
  // mode change may leave the divider counters part way through.
  task automatic gap(output int g);
    for (int n = 0; n < 3; n++) begin
      g = 0;
      do begin
        @(posedge clk);
        g++;
      end while (bit_tick !== 1'b1 && g < 3000);
      if (g >= 3000) begin
        failures++;
        give_verdict();
      end
    end
  endtask

  // Cycles between two rising edges of the card clock.
  task automatic sck_period(output int g);
    int   first = -1;
    logic prev;
    prev = sck;
    g = 0;
    for (int k = 0; k < 200; k++) begin
      @(posedge clk);
      if (sck === 1'b1 && prev !== 1'b1) begin
        if (first >= 0) begin
          g = k - first;
          break;
        end
        first = k;
      end
      prev = sck;
    end
    if (g == 0) begin
      failures++;
      give_verdict();
    end
  endtask

  // Bit ticks seen while the transmit line is held after a character.
  task automatic hold_ticks(output int g);
    bit seen = 1'b0;
    int k;
    g = 0;
    for (k = 0; k < 2500; k++) begin
      @(posedge clk);
      if (tx_hold === 1'b1) seen = 1'b1;
      if (tx_hold === 1'b1 && bit_tick === 1'b1) g++;
      if ((seen && tx_hold !== 1'b1) || (!seen && k > 4)) break;
    end
    if (k >= 2500) begin
      failures++;
      give_verdict();
    end
  endtask

  // ==========================================================
  // Main sequence.
  initial begin
    logic [31:0] v;
    int g;
    int t;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values, then random writes through the model.
    mdl = '{32'h0, 32'h174, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    for (int a = 0; a < 8; a++) rd(8'(a * 4), mdl[a]); // Reset.
    for (int a = 0; a < 8; a++) begin
      v = rnd();
      wr(8'(a * 4), v);
      if (a != 2 && a != 6) mdl[a] = v & msk(a);
    end
    wr(8'h20, rnd());
    for (int a = 0; a < 9; a++) begin
      rd(8'(a * 4), a < 8 ? mdl[a % 8] : 32'h0); // Masked.
    end
    // Error total: counting, clear on read, saturation and interrupt.
    wr(OFF_IRQ_MASK, 32'h0);
    t = int'(rnd() % 30) + 1;
    i_utg_peer.errors(t);
    repeat (2) @(posedge clk);
    `CHK("irq masked", 1'b0, irq) // Masked stays quiet.
    rd(OFF_ERROR_COUNT, 32'(t)); // Running total.
    rd(OFF_ERROR_COUNT, 32'h0); // Cleared by the read.
    i_utg_peer.errors(260);
    rd(OFF_ERROR_COUNT, 32'hff); // Saturated total.
    wr(OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    `CHK("irq raised", 1'b1, irq) // Error raises the line.
    wr(OFF_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    `CHK("irq cleared", 1'b0, irq) // Cleared by a one.
    // Timeguard at divider 1 and oversampling 8, edge values included.
    wr(OFF_CLOCK_DIVIDER, 32'h1);
    wr(OFF_CONTROL, 32'h2);
    for (int i = 0; i < 4; i++) begin
      t = (i == 0) ? 0 : (i == 1) ? 1 : 255;
      if (i == 2) t = int'(rnd() % 254) + 1;
      wr(OFF_TX_TIMEGUARD, 32'(t));
      i_utg_peer.char_end();
      hold_ticks(g);
      `CHK("guard ticks", t, g) // Idle bit periods.
      rd(OFF_IRQ_STATUS, t != 0 ? 32'h2 : 32'h0); // Done flag.
      wr(OFF_IRQ_STATUS, 32'h2);
    end
    // Bit period in each oversampling mode and in smart-card mode.
    t = int'(rnd() % 3) + 1;
    wr(OFF_CLOCK_DIVIDER, 32'(t));
    wr(OFF_CONTROL, 32'h0);
    gap(g);
    `CHK("period x16", 16 * t, g) // Full oversampling.
    wr(OFF_CONTROL, 32'h2);
    gap(g);
    `CHK("period x8", 8 * t, g) // Reduced oversampling.
    `CHK("sck idle", 1'b0, sck) // No card clock outside card mode.
    wr(OFF_CARD_RATIO, 32'h5);
    wr(OFF_CONTROL, 32'h1);
    gap(g);
    `CHK("card period", 5 * 2 * t, g) // Ratio card clock periods.
    sck_period(g);
    `CHK("sck period", 2 * t, g) // Two divider periods.
    wr(OFF_CARD_RATIO, 32'h0);
    repeat (4) @(posedge clk);
    g = 0;
    repeat (200) begin
      @(posedge clk);
      if (bit_tick === 1'b1) g++;
    end
    `CHK("ratio zero ticks", 0, g) // No bit clock.
    // Infrared filter: a short low is dropped, a long one passes.
    t = int'(rnd() % 6) + 2;
    wr(OFF_INFRARED, 32'(t));
    g = lows;
    i_utg_peer.ir_low(t - 1);
    repeat (6) @(posedge clk);
    `CHK("short pulse", g, lows) // Filtered out.
    i_utg_peer.ir_low(t + 4);
    repeat (4) @(posedge clk);
    `CHK("long pulse", 4, lows - g) // Pulse minus filter length.
    give_verdict();
  end
endmodule

// File: bench/utg_peer.sv
/*
  Serial line peer beside the auxiliary registers: it ends characters,
  raises card errors and shapes the infrared receive level.
  Assumes the bench calls its tasks just after a rising clock edge.
*/
`timescale 1ns/10ps
module utg_peer (
  input  wire logic i_clock,
  output logic      o_char_done,
  output logic      o_card_error,
  output logic      o_irda_rx
);
  // ==========================================================
  // Idle levels; the infrared line rests high like a real receiver.
  initial begin
    o_char_done  = 1'b0;
    o_card_error = 1'b0;
    o_irda_rx    = 1'b1;
  end

  // One character has left the shift register: a single-cycle pulse.
  task automatic char_end();
    @(posedge i_clock);
    o_char_done <= 1'b1;
    @(posedge i_clock);
    o_char_done <= 1'b0;
  endtask

  // A card error held for n cycles, which the block counts n times.
  task automatic errors(input int n);
    @(posedge i_clock);
    o_card_error <= 1'b1;
    repeat (n) @(posedge i_clock);
    o_card_error <= 1'b0;
  endtask

  // An infrared low pulse of n cycles, then back to the idle level.
  task automatic ir_low(input int n);
    @(posedge i_clock);
    o_irda_rx <= 1'b0;
    repeat (n) @(posedge i_clock);
    o_irda_rx <= 1'b1;
  endtask
endmodule

// File: src/utg_aux_regs.sv
/*
  Auxiliary registers of a serial transceiver: transmit timeguard,
  smart-card clock ratio and bit clock, error counter cleared on read,
  infrared receive pulse filter, and a small interrupt block, all on
  an AHB-Lite slave port with zero wait states.
  Assumes a single AHB-Lite master, the transmitter's character-done
  pulse and the card error pulse on i_clock, and an asynchronous
  infrared receive pin.
*/
// Design decisions made here: register access over AHB-Lite and the register offsets.
// Contract
// - Timeguard value zero adds no idle time between characters.
// - Timeguard 1..255 holds the line idle for that many bit periods.
// - Smart-card mode with ratio zero produces no bit clock.
// - Smart-card bit rate is serial clock divided by the ratio.
// - Every smart-card error increments a readable error total; the total saturates at 255.
// - Reading the error count returns it and then clears it.
// - The infrared filter value sets the receive pulse filter.
// - Async bit rate is clock divided by divider and 16, or 8.
`timescale 1ns/10ps
module utg_aux_regs (
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  input  wire logic        i_char_done,
  input  wire logic        i_card_error,
  input  wire logic        i_irda_rx,
  output logic             o_tx_hold,
  output logic             o_sck,
  output logic             o_bit_tick,
  output logic             o_irda_rx_filtered,
  output logic             o_irq
);
  import utg_pkg::*;

  // ==========================================================
  // Register storage.
  logic [GUARD_W-1:0]   guard_bits_q;
  logic [RATIO_W-1:0]   card_clock_ratio_q;
  logic [ERROR_W-1:0]   error_total_q;
  logic [FILTER_W-1:0]  filter_q;
  logic [DIVIDER_W-1:0] clock_divider_value_q;
  logic                 iso_mode_q;
  logic                 over_q;
  logic [IRQ_W-1:0]     irq_status_q;
  logic [IRQ_W-1:0]     irq_mask_q;

  // ==========================================================
  // AHB-Lite address phase decode.
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;
  wire        phase_ok  = i_hsel && i_hready && i_htrans[1];
  wire        rd_take   = phase_ok && !i_hwrite;
  wire        wr_take   = phase_ok && i_hwrite;
  wire [7:0]  rd_off    = i_haddr[7:0];
  wire        rd_errors = rd_take && (rd_off == OFF_ERROR_COUNT);
  wire        wr_guard  = wr_pend_q && (wr_addr_q == OFF_TX_TIMEGUARD);
  wire        wr_ratio  = wr_pend_q && (wr_addr_q == OFF_CARD_RATIO);
  wire        wr_filter = wr_pend_q && (wr_addr_q == OFF_INFRARED);
  wire        wr_ctrl   = wr_pend_q && (wr_addr_q == OFF_CONTROL);
  wire        wr_div    = wr_pend_q && (wr_addr_q == OFF_CLOCK_DIVIDER);
  wire        wr_stat   = wr_pend_q && (wr_addr_q == OFF_IRQ_STATUS);
  wire        wr_mask   = wr_pend_q && (wr_addr_q == OFF_IRQ_MASK);

  // Read mux; unused bits and unmapped offsets read as zero.
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (rd_off)
      OFF_TX_TIMEGUARD:  rd_word[GUARD_W-1:0]   = guard_bits_q;
      OFF_CARD_RATIO:    rd_word[RATIO_W-1:0]   = card_clock_ratio_q;
      OFF_ERROR_COUNT:   rd_word[ERROR_W-1:0]   = error_total_q;
      OFF_INFRARED:      rd_word[FILTER_W-1:0]  = filter_q;
      OFF_CONTROL: begin
        rd_word[CTRL_ISO_BIT]  = iso_mode_q;
        rd_word[CTRL_OVER_BIT] = over_q;
      end
      OFF_CLOCK_DIVIDER: rd_word[DIVIDER_W-1:0] = clock_divider_value_q;
      OFF_IRQ_STATUS:    rd_word[IRQ_W-1:0]     = irq_status_q;
      OFF_IRQ_MASK:      rd_word[IRQ_W-1:0]     = irq_mask_q;
      default:           rd_word = 32'h0000_0000;
    endcase
  end

  // Bus handshake: read data is captured at the address phase so it
  // stands through the whole data phase; the slave never waits.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 8'h00;
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      wr_pend_q   <= wr_take;
      wr_addr_q   <= i_haddr[7:0];
      o_hrdata    <= rd_take ? rd_word : o_hrdata;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
  end

  // Software-written configuration; only field bits are kept.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      guard_bits_q          <= GUARD_RESET;
      card_clock_ratio_q    <= RATIO_RESET;
      filter_q              <= FILTER_RESET;
      clock_divider_value_q <= DIVIDER_RESET;
      iso_mode_q            <= 1'b0;
      over_q                <= 1'b0;
      irq_mask_q            <= '0;
    end else begin
      if (wr_guard)  guard_bits_q       <= i_hwdata[GUARD_W-1:0];
      if (wr_ratio)  card_clock_ratio_q <= i_hwdata[RATIO_W-1:0];
      if (wr_filter) filter_q           <= i_hwdata[FILTER_W-1:0];
      if (wr_div)    clock_divider_value_q <= i_hwdata[DIVIDER_W-1:0];
      if (wr_ctrl) begin
        iso_mode_q <= i_hwdata[CTRL_ISO_BIT];
        over_q     <= i_hwdata[CTRL_OVER_BIT];
      end
      if (wr_mask)   irq_mask_q         <= i_hwdata[IRQ_W-1:0];
    end
  end

  // ==========================================================
  // Baud generation.
  // The first stage divides the clock by the divider value; the second
  // divides those ticks by twice the card ratio or by the oversampling ratio.
  logic               sel_tick;
  logic [RATIO_W-1:0] second_div;
  wire  [RATIO_W-1:0] over_ratio =
    over_q ? OVERSAMPLE_REDUCED : OVERSAMPLE_FULL;
  assign second_div = iso_mode_q ? card_clock_ratio_q : over_ratio;

  // In smart-card mode the second stage counts whole card clock periods,
  // so the bit rate is the card clock frequency over the ratio.
  wire  bit_enable =
    iso_mode_q ? (sel_tick && o_sck) : sel_tick;

  utg_divider #(.WIDTH(DIVIDER_W)) u_clock_div (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_enable  (1'b1),
    .i_divisor (clock_divider_value_q),
    .o_tick    (sel_tick)
  );

  // In smart-card mode a zero ratio stops this stage, so no bit clock appears.
  utg_divider #(.WIDTH(RATIO_W)) u_bit_div (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_enable  (bit_enable),
    .i_divisor (second_div),
    .o_tick    (o_bit_tick)
  );

  // The card clock toggles on every first-stage tick in smart-card mode.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || !iso_mode_q) begin
      o_sck <= 1'b0;
    end else if (sel_tick) begin
      o_sck <= !o_sck;
    end
  end

  // ==========================================================
  // Transmit timeguard.
  // The hold starts on the character-done pulse and is counted in bit
  // ticks; the transmitter ends a character on a bit tick, so the first
  // counted period is a whole one. A pulse off that grid shortens it.
  logic [GUARD_W-1:0] guard_cnt_q;
  wire guard_start = i_char_done && (guard_bits_q != '0);
  wire guard_last  = o_tx_hold && o_bit_tick &&
                     (guard_cnt_q == GUARD_W'(1));
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      guard_cnt_q <= '0;
      o_tx_hold   <= 1'b0;
    end else if (guard_start) begin
      guard_cnt_q <= guard_bits_q;
      o_tx_hold   <= 1'b1;
    end else if (o_tx_hold && o_bit_tick) begin
      guard_cnt_q <= guard_cnt_q - GUARD_W'(1);
      o_tx_hold   <= !guard_last;
    end
  end

  // ==========================================================
  // Smart-card error total, saturating so it never wraps to a small
  // value. An error in the clearing cycle is kept as a count of one.
  wire err_full = (error_total_q == {ERROR_W{1'b1}});
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      error_total_q <= '0;
    end else if (rd_errors) begin
      error_total_q <= i_card_error ? ERROR_W'(1) : '0;
    end else if (i_card_error && !err_full) begin
      error_total_q <= error_total_q + ERROR_W'(1);
    end
  end

  // ==========================================================
  // Infrared receive filter.
  // The pin passes two flip-flops; a low level reaches the output only
  // after it has stayed low for more than the programmed number of cycles,
  // which rejects glitches of that length or shorter.
  logic                rx_meta_q;
  logic                rx_sync_q;
  logic [FILTER_W-1:0] low_cnt_q;
  wire                 low_long = (low_cnt_q >= filter_q);
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rx_meta_q          <= 1'b1;
      rx_sync_q          <= 1'b1;
      low_cnt_q          <= '0;
      o_irda_rx_filtered <= 1'b1;
    end else begin
      rx_meta_q <= i_irda_rx;
      rx_sync_q <= rx_meta_q;
      if (rx_sync_q) begin
        low_cnt_q          <= '0;
        o_irda_rx_filtered <= 1'b1;
      end else begin
        if (!low_long) low_cnt_q <= low_cnt_q + FILTER_W'(1);
        if (low_long)  o_irda_rx_filtered <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Interrupts: events set sticky bits; writing one clears a bit, but
  // an event in the same cycle wins over the clear.
  wire [IRQ_W-1:0] irq_event = {guard_last, i_card_error};
  wire [IRQ_W-1:0] irq_clear = wr_stat ? i_hwdata[IRQ_W-1:0] : '0;
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      irq_status_q <= '0;
      o_irq        <= 1'b0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
      o_irq        <= |(irq_status_q & irq_mask_q);
    end
  end

  // ==========================================================
  // Assertions.
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  // Helper for the rate checks: divider ticks since the last bit tick,
  // trusted only once a whole span has passed with no setting changed.
  logic [RATIO_W:0] span_ticks_q;
  logic             span_ok_q;
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || wr_ctrl || wr_ratio || wr_div) begin
      span_ticks_q <= '0;
      span_ok_q    <= 1'b0;
    end else if (o_bit_tick) begin
      span_ticks_q <= {{RATIO_W{1'b0}}, sel_tick};
      span_ok_q    <= 1'b1;
    end else begin
      span_ticks_q <= span_ticks_q + {{RATIO_W{1'b0}}, sel_tick};
    end
  end

  property p_guard_off;
    i_char_done && guard_bits_q == '0 && !o_tx_hold |=> !o_tx_hold;
  endproperty
  a_guard_off: assert property (p_guard_off)
    else $error("Timeguard held the line while disabled.");

  property p_guard_on;
    guard_start |=> o_tx_hold && guard_cnt_q == $past(guard_bits_q);
  endproperty
  a_guard_on: assert property (p_guard_on)
    else $error("Timeguard did not load its value.");

  property p_guard_end;
    guard_last && !guard_start
      |=> !o_tx_hold && irq_status_q[IRQ_GUARD_BIT];
  endproperty
  a_guard_end: assert property (p_guard_end)
    else $error("Timeguard did not end after its last bit.");

  property p_ratio_zero;
    (iso_mode_q && card_clock_ratio_q == '0) [*2] |-> !o_bit_tick;
  endproperty
  a_ratio_zero: assert property (p_ratio_zero)
    else $error("Bit clock ran with a zero card ratio.");

  property p_bit_from_sel;
    o_bit_tick |-> $past(sel_tick);
  endproperty
  a_bit_from_sel: assert property (p_bit_from_sel)
    else $error("Bit tick without a divider tick.");

  property p_err_inc;
    i_card_error && !rd_errors && !err_full
      |=> error_total_q == $past(error_total_q) + ERROR_W'(1);
  endproperty
  a_err_inc: assert property (p_err_inc)
    else $error("Error total did not count an error.");

  property p_err_read;
    rd_errors && !i_card_error
      |=> error_total_q == '0 && o_hrdata[ERROR_W-1:0] ==
          $past(error_total_q);
  endproperty
  a_err_read: assert property (p_err_read)
    else $error("Error count read did not return and clear.");

  property p_irda_high;
    rx_sync_q |=> o_irda_rx_filtered && low_cnt_q == '0;
  endproperty
  a_irda_high: assert property (p_irda_high)
    else $error("Filter output not high after a high input.");

  property p_async_ratio;
    o_bit_tick && span_ok_q && !iso_mode_q
      |-> span_ticks_q == {1'b0, over_ratio};
  endproperty
  a_async_ratio: assert property (p_async_ratio)
    else $error("Asynchronous oversampling ratio is wrong.");

  property p_card_ratio;
    o_bit_tick && span_ok_q && iso_mode_q
      |-> span_ticks_q == {card_clock_ratio_q, 1'b0};
  endproperty
  a_card_ratio: assert property (p_card_ratio)
    else $error("Card bit period is not ratio card clock periods.");

  property p_reserved;
    rd_take && rd_off == OFF_TX_TIMEGUARD |=> o_hrdata[31:GUARD_W] == '0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("Unused timeguard bits read nonzero.");

  c_guard_done: cover property (guard_start ##[1:1000] guard_last);
  c_err_read:   cover property (i_card_error ##[1:50] rd_errors);
  c_irda_low:   cover property ($fell(o_irda_rx_filtered));
  c_irq:        cover property ($rose(o_irq));
endmodule

// File: src/utg_divider.sv
/*
  Programmable tick divider: emits one single-cycle tick for every
  divisor enabled cycles; a divisor of zero stops the ticks.
  Assumes the enable is a single-cycle pulse or level on i_clock.
*/
`timescale 1ns/10ps
module utg_divider #(
  parameter int WIDTH = 16
) (
  input  wire logic             i_clock,
  input  wire logic             i_sys_rst,
  input  wire logic             i_enable,
  input  wire logic [WIDTH-1:0] i_divisor,
  output logic                  o_tick
);
  // ==========================================================
  // Counter state.
  logic [WIDTH-1:0] count_q;
  wire              stopped = (i_divisor == '0);
  wire              wrap    = (count_q >= i_divisor - WIDTH'(1));

  // Count enabled cycles; restart whenever the divisor is zero.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || stopped) begin
      count_q <= '0;
      o_tick  <= 1'b0;
    end else if (i_enable) begin
      count_q <= wrap ? '0 : count_q + WIDTH'(1);
      o_tick  <= wrap;
    end else begin
      o_tick  <= 1'b0;
    end
  end
endmodule

// File: src/utg_pkg.sv
/*
  Shared constants of the serial auxiliary register block: register
  offsets, field widths, reset values and fixed oversampling ratios.
  Assumes it is compiled before every design file that imports it.
*/
package utg_pkg;
  // ==========================================================
  // Register offsets (byte addresses, one aligned word each).
  localparam logic [7:0] OFF_TX_TIMEGUARD   = 8'h00;
  localparam logic [7:0] OFF_CARD_RATIO     = 8'h04;
  localparam logic [7:0] OFF_ERROR_COUNT    = 8'h08;
  localparam logic [7:0] OFF_INFRARED       = 8'h0c;
  localparam logic [7:0] OFF_CONTROL        = 8'h10;
  localparam logic [7:0] OFF_CLOCK_DIVIDER  = 8'h14;
  localparam logic [7:0] OFF_IRQ_STATUS     = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK       = 8'h1c;

  // ==========================================================
  // Field widths and reset values.
  localparam int GUARD_W   = 8;
  localparam int RATIO_W   = 11;
  localparam int ERROR_W   = 8;
  localparam int FILTER_W  = 8;
  localparam int DIVIDER_W = 16;
  localparam int IRQ_W     = 2;
  localparam logic [RATIO_W-1:0]   RATIO_RESET   = 11'h174;
  localparam logic [GUARD_W-1:0]   GUARD_RESET   = 8'h00;
  localparam logic [FILTER_W-1:0]  FILTER_RESET  = 8'h00;
  localparam logic [DIVIDER_W-1:0] DIVIDER_RESET = 16'h0000;

  // ==========================================================
  // Control bits and interrupt status bits.
  localparam int CTRL_ISO_BIT   = 0;
  localparam int CTRL_OVER_BIT  = 1;
  localparam int IRQ_ERROR_BIT  = 0;
  localparam int IRQ_GUARD_BIT  = 1;

  // ==========================================================
  // Oversampling ratios of the asynchronous bit clock.
  localparam logic [RATIO_W-1:0] OVERSAMPLE_FULL    = 11'h010;
  localparam logic [RATIO_W-1:0] OVERSAMPLE_REDUCED = 11'h008;
endpackage
